/* rtl/glm_load_sequencer.sv */
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module glm_load_sequencer #(
  parameter int unsigned DEB_CYC = glm_pkg::DEB_CYC_DFLT,
  parameter int unsigned TICK_CYC = glm_pkg::TICK_CYC_DFLT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire glm_pkg::glm_contacts_s contactsIn,
  input wire logic sensorFailed,
  input wire logic sensorReset,
  input wire logic [15:0] sensorLoad,
  input wire logic [15:0] fuelDemand,
  input wire logic [15:0] shareRef,
  output logic breakerOpenRelay,
  output logic [15:0] loadRef,
  output logic [15:0] droopSet,
  output logic signed [15:0] droopBias,
  output logic loadBiasEnable,
  output glm_pkg::glm_mode_e mode,
  output logic sensorAlarm
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] stepTo(input logic [15:0] cur,
                                          input logic [15:0] tgt,
                                          input logic [15:0] rate);
    logic [16:0] sum;
    sum = {1'b0, cur} + {1'b0, rate};
    if (cur < tgt)
      stepTo = (sum >= {1'b0, tgt}) ? tgt : sum[15:0];
    else if (cur - tgt > rate)
      stepTo = cur - rate;
    else
      stepTo = tgt;
  endfunction : stepTo

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a <= glm_pkg::OFS_LOADREF) && (a[1:0] == 2'h0);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned CNT_W = glm_pkg::CNT_W;
  localparam logic [CNT_W-1:0] DEB_MAX = CNT_W'(DEB_CYC - 1);
  localparam logic [CNT_W-1:0] TICK_MAX = CNT_W'(TICK_CYC - 1);

  glm_pkg::glm_state_s q, d;
  logic bc, lc, bl, rs, lw;
  logic sensorBad, droopMode, useRate2;
  logic [15:0] rate, fuelLoad, fbLoad, baseTgt, loadTgt;
  logic [31:0] fuelSpan, fuelScaled, droopProd, rdVal;

  assign bc = q.stable.breakerClosedContact;
  assign lc = q.stable.loadCommand;
  assign bl = q.stable.baseLoad;
  assign rs = q.stable.raiseInput;
  assign lw = q.stable.lowerInput;
  assign sensorBad = sensorFailed | ~sensorReset;
  assign useRate2 = q.cfg.ctrl[glm_pkg::CTRL_RATE2_EN] & q.stable.rate2Select;
  assign rate = useRate2 ? q.cfg.rate2 : q.cfg.rate1;

  // fuel span of zero gives no load rather than a divide fault
  assign fuelSpan = {16'h0000, q.cfg.fuelMax - q.cfg.fuelMin};
  assign fuelScaled = (fuelDemand <= q.cfg.fuelMin
                       || q.cfg.fuelMax <= q.cfg.fuelMin) ? 32'h0 :
    ({16'h0000, fuelDemand - q.cfg.fuelMin} * {16'h0000, q.cfg.ratedLoad})
    / fuelSpan;
  assign fuelLoad = (fuelScaled > {16'h0000, q.cfg.ratedLoad}) ?
    q.cfg.ratedLoad : fuelScaled[15:0];
  assign fbLoad = (sensorBad || q.mode == glm_pkg::FUEL_DROOP_MODE
                   || q.mode == glm_pkg::FUEL_ISOCH_MODE)
    ? fuelLoad : sensorLoad;
  assign droopMode = (q.mode == glm_pkg::SENSOR_DROOP_MODE)
    || (q.mode == glm_pkg::FUEL_DROOP_MODE);
  assign droopProd = {16'h0000, fbLoad} * {16'h0000, q.cfg.droopGain};

  // base load reference target from raise and lower
  always_comb
  begin
    if (rs && lw)
      baseTgt = q.cfg.remoteSet;
    else if (rs)
      baseTgt = q.cfg.ratedLoad;
    else if (lw)
      baseTgt = q.cfg.tripLevel;
    else
      baseTgt = q.cfg.baseRefInt;
    loadTgt = bl ? q.baseRef : shareRef;
  end

  always_comb
  begin
    if (paddr == glm_pkg::OFS_CTRL)
      rdVal = {28'h0, q.cfg.ctrl};
    else if (paddr == glm_pkg::OFS_RATE1)
      rdVal = {16'h0, q.cfg.rate1};
    else if (paddr == glm_pkg::OFS_RATE2)
      rdVal = {16'h0, q.cfg.rate2};
    else if (paddr == glm_pkg::OFS_TRIP)
      rdVal = {16'h0, q.cfg.tripLevel};
    else if (paddr == glm_pkg::OFS_RATED)
      rdVal = {16'h0, q.cfg.ratedLoad};
    else if (paddr == glm_pkg::OFS_BASEREF)
      rdVal = {16'h0, q.cfg.baseRefInt};
    else if (paddr == glm_pkg::OFS_REMOTE)
      rdVal = {16'h0, q.cfg.remoteSet};
    else if (paddr == glm_pkg::OFS_FUELMIN)
      rdVal = {16'h0, q.cfg.fuelMin};
    else if (paddr == glm_pkg::OFS_FUELMAX)
      rdVal = {16'h0, q.cfg.fuelMax};
    else if (paddr == glm_pkg::OFS_PULSE)
      rdVal = {16'h0, q.cfg.pulseMs};
    else if (paddr == glm_pkg::OFS_GAIN)
      rdVal = {16'h0, q.cfg.droopGain};
    else if (paddr == glm_pkg::OFS_STATUS)
      rdVal = {16'h0, q.baseRef[7:0], q.stable[5:0], q.mode[1], q.mode[0]}
        ^ {16'h0, 8'h0, 2'h0, q.relayOpen, q.seq, q.sensorAlarm, 1'b0}
        ^ {16'h0, q.baseRef[7:0], 8'h0};
    else if (paddr == glm_pkg::OFS_LOADREF)
      rdVal = {q.baseRef, q.loadRef};
    else
      rdVal = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    // two-flop sync, then a stable-for-DEB_CYC filter per contact
    d.sync1 = contactsIn;
    d.sync2 = q.sync1;
    for (int i = 0; i < 6; i++)
    begin
      if (q.sync2[i] == q.stable[i])
        d.deb[i] = '0;
      else if (q.deb[i] >= DEB_MAX)
      begin
        d.stable[i] = q.sync2[i];
        d.deb[i] = '0;
      end
      else
        d.deb[i] = q.deb[i] + CNT_W'(1);
    end
    if (q.tickCnt >= TICK_MAX)
    begin
      d.tickCnt = '0;
      d.tick = 1'b1;
    end
    else
      d.tickCnt = q.tickCnt + CNT_W'(1);
    d.bcPrev = bc;
    d.lcPrev = lc;

    // mode table
    if (!bc)
      d.mode = (sensorBad || q.cfg.ctrl[glm_pkg::CTRL_FUEL_DROOP])
        ? glm_pkg::FUEL_DROOP_MODE : glm_pkg::SENSOR_DROOP_MODE;
    else if (!sensorBad)
      d.mode = glm_pkg::SENSOR_ISOCH_MODE;
    else
      d.mode = q.cfg.ctrl[glm_pkg::CTRL_FUEL_ISOCH]
        ? glm_pkg::FUEL_ISOCH_MODE : glm_pkg::FUEL_DROOP_MODE;
    d.sensorAlarm = sensorBad;
    d.droopPrev = droopMode;
    // bias follows the next mode so it switches in step with mode
    d.droopBias = (d.mode == glm_pkg::SENSOR_DROOP_MODE
                   || d.mode == glm_pkg::FUEL_DROOP_MODE) ? -$signed({1'b0,
      droopProd[glm_pkg::GAIN_SHIFT +: 15]}) : 16'sh0000;

    if (q.tick && q.seq != glm_pkg::SEQ_DROOP)
      d.baseRef = stepTo(q.baseRef, baseTgt, rate);

    case (q.seq)
      glm_pkg::SEQ_DROOP:
      begin
        d.relayOpen = 1'b0;
        // base load has no say here; load command only picks the sequence at breaker close
        if (q.tick && rs && lw)
          d.droopSet = stepTo(q.droopSet, q.cfg.remoteSet, rate);
        else if (q.tick && rs)
          d.droopSet = stepTo(q.droopSet, q.cfg.ratedLoad, rate);
        else if (q.tick && lw)
          d.droopSet = stepTo(q.droopSet, 16'h0000, rate);
        if (bc && !q.bcPrev)
        begin
          d.baseRef = q.cfg.baseRefInt;
          if (lc)
          begin
            d.seq = glm_pkg::SEQ_LOADING;
            d.loadRef = q.cfg.ctrl[glm_pkg::CTRL_BUMPLESS]
              ? fbLoad : 16'h0000;
          end
          else
          begin
            d.seq = glm_pkg::SEQ_HOLD;
            d.loadRef = q.cfg.tripLevel;
          end
        end
      end
      glm_pkg::SEQ_LOADING:
      begin
        if (!lc)
        begin
          d.seq = glm_pkg::SEQ_UNLOADING;
          d.holdCnt = 16'h0000;
        end
        else if (q.tick)
          d.loadRef = stepTo(q.loadRef, loadTgt, rate);
      end
      glm_pkg::SEQ_UNLOADING:
      begin
        if (q.tick)
          d.loadRef = stepTo(q.loadRef, q.cfg.tripLevel, rate);
        if (q.tick && q.loadRef == q.cfg.tripLevel)
          d.holdCnt = q.holdCnt + 16'h0001;
        if (lc)
          d.seq = glm_pkg::SEQ_LOADING;
        else if (fbLoad <= q.cfg.tripLevel
                 || q.holdCnt >= glm_pkg::UNLOAD_HOLD_TICKS)
        begin
          d.seq = glm_pkg::SEQ_TRIP;
          d.relayOpen = 1'b1;
          d.pulseCnt = 16'h0000;
        end
      end
      glm_pkg::SEQ_TRIP:
      begin
        d.loadRef = q.cfg.tripLevel;
        if (q.tick)
          d.pulseCnt = q.pulseCnt + 16'h0001;
        if (q.tick && q.pulseCnt >= q.cfg.pulseMs)
        begin
          d.relayOpen = 1'b0;
          d.seq = glm_pkg::SEQ_HOLD;
        end
      end
      glm_pkg::SEQ_HOLD:
      begin
        d.loadRef = q.cfg.tripLevel;
        if (lc)
          d.seq = glm_pkg::SEQ_LOADING;
      end
      default:
        d.seq = glm_pkg::SEQ_DROOP;
    endcase

    // breaker open overrides every sequence but a running trip pulse,
    // which the opening breaker itself would otherwise cut short
    if (!bc && q.seq != glm_pkg::SEQ_TRIP)
    begin
      d.seq = glm_pkg::SEQ_DROOP;
      d.relayOpen = 1'b0;
      if (q.seq != glm_pkg::SEQ_DROOP && q.cfg.ctrl[glm_pkg::CTRL_BUMPLESS])
        d.droopSet = fbLoad;
    end

    // apb: zero wait, read data latched in the setup cycle
    if (psel && !penable)
    begin
      d.prdata = rdVal;
      d.pslverr = ~mapped(paddr);
    end
    if (psel && penable && pwrite)
    begin
      if (paddr == glm_pkg::OFS_CTRL)
        d.cfg.ctrl = pwdata[3:0];
      else if (paddr == glm_pkg::OFS_RATE1)
        d.cfg.rate1 = pwdata[15:0];
      else if (paddr == glm_pkg::OFS_RATE2)
        d.cfg.rate2 = pwdata[15:0];
      else if (paddr == glm_pkg::OFS_TRIP)
        d.cfg.tripLevel = pwdata[15:0];
      else if (paddr == glm_pkg::OFS_RATED)
        d.cfg.ratedLoad = pwdata[15:0];
      else if (paddr == glm_pkg::OFS_BASEREF)
        d.cfg.baseRefInt = pwdata[15:0];
      else if (paddr == glm_pkg::OFS_REMOTE)
        d.cfg.remoteSet = pwdata[15:0];
      else if (paddr == glm_pkg::OFS_FUELMIN)
        d.cfg.fuelMin = pwdata[15:0];
      else if (paddr == glm_pkg::OFS_FUELMAX)
        d.cfg.fuelMax = pwdata[15:0];
      else if (paddr == glm_pkg::OFS_PULSE)
        d.cfg.pulseMs = pwdata[15:0];
      else if (paddr == glm_pkg::OFS_GAIN)
        d.cfg.droopGain = pwdata[15:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.cfg.ctrl <= glm_pkg::CTRL_RST;
      q.cfg.rate1 <= glm_pkg::RATE_RST;
      q.cfg.rate2 <= glm_pkg::RATE_RST;
      q.cfg.tripLevel <= glm_pkg::TRIP_RST;
      q.cfg.ratedLoad <= glm_pkg::RATED_RST;
      q.cfg.baseRefInt <= glm_pkg::BASEREF_RST;
      q.cfg.fuelMin <= glm_pkg::FUELMIN_RST;
      q.cfg.fuelMax <= glm_pkg::FUELMAX_RST;
      q.cfg.pulseMs <= glm_pkg::PULSE_RST;
      q.cfg.droopGain <= glm_pkg::GAIN_RST;
      q.seq <= glm_pkg::SEQ_DROOP;
      q.mode <= glm_pkg::SENSOR_DROOP_MODE;
    end
    else
      q <= d;
  end

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = q.pslverr;
  assign breakerOpenRelay = q.relayOpen;
  assign loadRef = q.loadRef;
  assign droopSet = q.droopSet;
  assign droopBias = q.droopBias;
  assign loadBiasEnable = ~droopMode;
  assign mode = q.mode;
  assign sensorAlarm = q.sensorAlarm;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_trip_step: assert property (q.seq == glm_pkg::SEQ_DROOP && bc
    && !q.bcPrev && !lc |=> q.loadRef == $past(q.cfg.tripLevel))
    else $error("no step to trip level on unload close");
  a_load_start: assert property (q.seq == glm_pkg::SEQ_DROOP && bc
    && !q.bcPrev && lc |=> q.seq == glm_pkg::SEQ_LOADING)
    else $error("load sequence not started");
  a_ramp_rate: assert property (q.seq == glm_pkg::SEQ_LOADING && lc
    |=> (q.loadRef >= $past(q.loadRef) ?
         q.loadRef - $past(q.loadRef) : $past(q.loadRef) - q.loadRef)
        <= $past(rate))
    else $error("ramp step exceeds rate");
  a_unload_entry: assert property (q.seq == glm_pkg::SEQ_LOADING && !lc
    && bc |=> q.seq == glm_pkg::SEQ_UNLOADING)
    else $error("unload not entered");
  a_relay_state: assert property ($rose(q.relayOpen)
    |-> $past(q.seq) == glm_pkg::SEQ_UNLOADING ##1 q.relayOpen)
    else $error("relay pulse out of sequence");
  a_hold_level: assert property (q.seq == glm_pkg::SEQ_HOLD && bc
    |=> q.loadRef == $past(q.cfg.tripLevel))
    else $error("hold not at trip level");
  a_droop_bias: assert property (!bc ##1 !bc
    |-> !loadBiasEnable && q.droopBias <= 16'sh0000)
    else $error("droop bias wrong with breaker open");
  a_isoch_zero: assert property (bc && !sensorBad
    |=> q.mode == glm_pkg::SENSOR_ISOCH_MODE && q.droopBias == 16'sh0000)
    else $error("isoch mode not selected");
  a_fuel_droop: assert property (!bc && sensorBad
    |=> q.mode == glm_pkg::FUEL_DROOP_MODE)
    else $error("fuel droop not selected");
  a_debounce: assert property ($changed(q.stable)
    |-> (($past(q.sync2) ^ q.stable) & ($past(q.stable) ^ q.stable))
        == 6'h00)
    else $error("contact changed without debounce");

  c_loaded: cover property (q.seq == glm_pkg::SEQ_LOADING
    && q.loadRef == loadTgt);
  c_trip: cover property ($fell(q.relayOpen));
  c_remote_base: cover property (q.seq == glm_pkg::SEQ_LOADING && bl
    && rs && lw);
endmodule : glm_load_sequencer

/* rtl/glm_pkg.sv */
package glm_pkg;
  // timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC_DFLT = CLK_MHZ * TICK_US;
  localparam int unsigned DEBOUNCE_US = 2000;
  localparam int unsigned DEB_CYC_DFLT = CLK_MHZ * DEBOUNCE_US;
  localparam int unsigned UNLOAD_HOLD_MS = 5000;
  localparam logic [15:0] UNLOAD_HOLD_TICKS =
    16'(UNLOAD_HOLD_MS * 1000 / TICK_US);
  localparam int unsigned PULSE_MS_DFLT = 1000;
  localparam int unsigned CNT_W = 20;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_RATE1 = 12'h004;
  localparam logic [11:0] OFS_RATE2 = 12'h008;
  localparam logic [11:0] OFS_TRIP = 12'h00c;
  localparam logic [11:0] OFS_RATED = 12'h010;
  localparam logic [11:0] OFS_BASEREF = 12'h014;
  localparam logic [11:0] OFS_REMOTE = 12'h018;
  localparam logic [11:0] OFS_FUELMIN = 12'h01c;
  localparam logic [11:0] OFS_FUELMAX = 12'h020;
  localparam logic [11:0] OFS_PULSE = 12'h024;
  localparam logic [11:0] OFS_GAIN = 12'h028;
  localparam logic [11:0] OFS_STATUS = 12'h02c;
  localparam logic [11:0] OFS_LOADREF = 12'h030;

  // control bits and droop gain shift
  localparam int unsigned CTRL_RATE2_EN = 0;
  localparam int unsigned CTRL_FUEL_DROOP = 1;
  localparam int unsigned CTRL_FUEL_ISOCH = 2;
  localparam int unsigned CTRL_BUMPLESS = 3;
  localparam int unsigned GAIN_SHIFT = 8;

  // reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] RATE_RST = 16'h0010;
  localparam logic [15:0] TRIP_RST = 16'h0064;
  localparam logic [15:0] RATED_RST = 16'h03e8;
  localparam logic [15:0] BASEREF_RST = 16'h01f4;
  localparam logic [15:0] FUELMIN_RST = 16'h0100;
  localparam logic [15:0] FUELMAX_RST = 16'h0f00;
  localparam logic [15:0] PULSE_RST = 16'(PULSE_MS_DFLT);
  localparam logic [15:0] GAIN_RST = 16'h000d;

  typedef enum logic [2:0] {
    SEQ_DROOP, SEQ_LOADING, SEQ_UNLOADING, SEQ_TRIP, SEQ_HOLD
  } glm_seq_e;

  typedef enum logic [1:0] {
    SENSOR_DROOP_MODE, FUEL_DROOP_MODE, SENSOR_ISOCH_MODE, FUEL_ISOCH_MODE
  } glm_mode_e;

  typedef struct packed {
    logic rate2Select;
    logic lowerInput;
    logic raiseInput;
    logic baseLoad;
    logic loadCommand;
    logic breakerClosedContact;
  } glm_contacts_s;

  typedef struct packed {
    logic [3:0] ctrl;
    logic [15:0] rate1;
    logic [15:0] rate2;
    logic [15:0] tripLevel;
    logic [15:0] ratedLoad;
    logic [15:0] baseRefInt;
    logic [15:0] remoteSet;
    logic [15:0] fuelMin;
    logic [15:0] fuelMax;
    logic [15:0] pulseMs;
    logic [15:0] droopGain;
  } glm_cfg_s;

  typedef struct packed {
    glm_contacts_s sync1;
    glm_contacts_s sync2;
    glm_contacts_s stable;
    logic [5:0][CNT_W-1:0] deb;
    logic bcPrev;
    logic lcPrev;
    logic [CNT_W-1:0] tickCnt;
    logic tick;
    glm_seq_e seq;
    logic [15:0] loadRef;
    logic [15:0] baseRef;
    logic [15:0] droopSet;
    logic [15:0] holdCnt;
    logic [15:0] pulseCnt;
    logic relayOpen;
    logic droopPrev;
    glm_mode_e mode;
    logic signed [15:0] droopBias;
    logic sensorAlarm;
    glm_cfg_s cfg;
    logic [31:0] prdata;
    logic pslverr;
  } glm_state_s;
endpackage : glm_pkg

/* test/glm_far_side.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// breaker with a chattering auxiliary contact, operator switches, trip path
module glm_far_side (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic closeReq,
  input wire logic loadSw,
  input wire logic baseSw,
  input wire logic raiseSw,
  input wire logic lowerSw,
  input wire logic rate2Sw,
  input wire logic breakerOpenRelay,
  output glm_pkg::glm_contacts_s contacts
);
  logic closedQ;
  logic [1:0] bounceQ;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      closedQ <= 1'b0;
      bounceQ <= 2'h0;
    end
    else if (breakerOpenRelay)
    begin
      // trip coil wins over a pending close
      closedQ <= 1'b0;
    end
    else if (closeReq && !closedQ)
    begin
      closedQ <= 1'b1;
      bounceQ <= 2'h3;
    end
    else if (bounceQ != 2'h0)
    begin
      bounceQ <= bounceQ - 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // aux contact chatters after closing, as real contacts do
  always_comb
  begin
    contacts.breakerClosedContact = closedQ & ~bounceQ[0];
    contacts.loadCommand = loadSw;
    contacts.baseLoad = baseSw;
    contacts.raiseInput = raiseSw;
    contacts.lowerInput = lowerSw;
    contacts.rate2Select = rate2Sw;
  end
endmodule : glm_far_side

/* test/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  localparam int unsigned DEB = 4;
  localparam int unsigned TICK = 8;
  localparam logic [15:0] TRIP = glm_pkg::TRIP_RST;
  typedef struct packed {logic [2:0] sel; logic [31:0] val;} glm_note_s;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, relay;
  logic sensorFailed, sensorReset, lbe, alarm, probeQ, tbFlag, closeReq;
  logic loadSw, baseSw, raiseSw, lowerSw, rate2Sw;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [15:0] sensorLoad, fuelDemand, shareRef, loadRef, droopSet;
  logic [15:0] remote, expv, mark;
  logic signed [15:0] droopBias;
  glm_pkg::glm_mode_e mode;
  glm_pkg::glm_contacts_s contacts;
  glm_note_s notes[$];
  glm_note_s cur;
  int fails, checksDone, cycles, i, k;
  ////////////////////////////////////////////////////////////////////////////
  always #2 sys_clk = ~sys_clk;
  glm_load_sequencer #(.DEB_CYC(DEB), .TICK_CYC(TICK)) i_glm_load_sequencer (
    .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .contactsIn(contacts),
    .sensorFailed(sensorFailed), .sensorReset(sensorReset),
    .sensorLoad(sensorLoad), .fuelDemand(fuelDemand), .shareRef(shareRef),
    .breakerOpenRelay(relay), .loadRef(loadRef), .droopSet(droopSet),
    .droopBias(droopBias), .loadBiasEnable(lbe), .mode(mode),
    .sensorAlarm(alarm));
  glm_far_side i_glm_far_side (
    .sys_clk(sys_clk), .rst(rst), .closeReq(closeReq), .loadSw(loadSw),
    .baseSw(baseSw), .raiseSw(raiseSw), .lowerSw(lowerSw),
    .rate2Sw(rate2Sw), .breakerOpenRelay(relay), .contacts(contacts));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checksDone++;
    if (seen !== want)
    begin
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
      fails++;
    end
  endtask : check
  task automatic finish_test();
    if (fails == 0 && checksDone > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // the slave answers when it likes; only the timeout ends a wait
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [2:0] sel, input logic [11:0] a,
                    input logic [31:0] want);
    notes.push_back({sel, want});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic probe(input logic [2:0] sel, input logic [31:0] want);
    notes.push_back({sel, want});
    @(posedge sys_clk);
    probeQ <= 1'b1;
    @(posedge sys_clk);
    probeQ <= 1'b0;
  endtask : probe
  task automatic settle();
    repeat (2 + DEB + 10) @(posedge sys_clk);
  endtask : settle
  task automatic waitRef(input logic [15:0] v);
    for (int n = 0; n < 4000 && loadRef !== v; n++)
      @(posedge sys_clk);
  endtask : waitRef
  ////////////////////////////////////////////////////////////////////////////
  // monitor: every read completion or probe retires the oldest note
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles > 30000)
    begin
      fails++;
      finish_test();
    end
    if ((psel && penable && pready && !pwrite) || probeQ)
    begin
      cur = notes.pop_front();
      case (cur.sel)
        3'h0: check(prdata, cur.val);
        3'h1: check({30'h0, mode}, cur.val);
        3'h2: check({16'h0, loadRef}, cur.val);
        3'h3: check({31'h0, pslverr}, cur.val);
        3'h4: check({31'h0, lbe}, cur.val);
        3'h5: check({31'h0, alarm}, cur.val);
        default: check({31'h0, tbFlag}, cur.val);
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {sys_clk, psel, penable, pwrite, probeQ, tbFlag, closeReq} = '0;
    {loadSw, baseSw, raiseSw, lowerSw, rate2Sw, sensorFailed} = '0;
    {paddr, pwdata, fails, checksDone, cycles} = '0;
    rst = 1'b1;
    sensorReset = 1'b1;
    seed = 32'd72943;
    sensorLoad = 16'h0100 + 16'(rnd() & 32'hff);
    fuelDemand = 16'(rnd());
    shareRef = 16'h0100 + 16'(rnd() & 32'h1ff);
    remote = 16'h0100 + 16'(rnd() & 32'h1ff);
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rd(0, glm_pkg::OFS_CTRL, 32'h0);
    rd(0, glm_pkg::OFS_RATE1, 32'h10);
    rd(0, glm_pkg::OFS_TRIP, 32'h64);
    rd(0, glm_pkg::OFS_PULSE, 32'h3e8);
    rd(3, 12'h040, 32'h1);
    apb(1'b1, glm_pkg::OFS_RATE1, 32'h40);
    apb(1'b1, glm_pkg::OFS_PULSE, 32'h3);
    apb(1'b1, glm_pkg::OFS_REMOTE, {16'h0, remote});
    // breaker open: droop table, load inputs must not matter
    for (i = 0; i < 4; i++)
    begin
      sensorFailed <= i[0];
      baseSw <= rnd() & 1;
      loadSw <= rnd() & 1;
      apb(1'b1, glm_pkg::OFS_CTRL, {30'h0, i[1], 1'b0});
      settle();
      probe(1, (i != 0) ? 1 : 0);
      probe(5, i[0]);
      probe(4, 0);
    end
    apb(1'b1, glm_pkg::OFS_CTRL, 32'h0);
    sensorFailed <= 1'b0;
    sensorReset <= 1'b0;
    settle();
    probe(1, 1);
    sensorReset <= 1'b1;
    settle();
    tbFlag <= droopBias[15];
    probe(7, 1);
    mark = droopSet;
    raiseSw <= 1'b1;
    repeat (10 * TICK) @(posedge sys_clk);
    tbFlag <= droopSet > mark;
    probe(7, 1);
    mark = droopSet;
    {raiseSw, lowerSw} <= 2'b01;
    repeat (5 * TICK) @(posedge sys_clk);
    tbFlag <= droopSet < mark;
    probe(7, 1);
    // close breaker without load command: straight to trip level
    {loadSw, baseSw, raiseSw, lowerSw} <= 4'h0;
    closeReq <= 1'b1;
    @(posedge sys_clk);
    closeReq <= 1'b0;
    settle();
    probe(2, TRIP);
    for (i = 0; i < 4; i++)
    begin
      sensorFailed <= i[0];
      apb(1'b1, glm_pkg::OFS_CTRL, {29'h0, i[1], 2'h0});
      settle();
      expv = !i[0] ? 16'h2 : (i[1] ? 16'h3 : 16'h1);
      probe(1, expv);
      probe(4, expv[1]);
    end
    sensorFailed <= 1'b0;
    apb(1'b1, glm_pkg::OFS_CTRL, 32'h0);
    // soft load into load sharing, then the base load table
    loadSw <= 1'b1;
    repeat (2 + DEB + 3) @(posedge sys_clk);
    tbFlag <= loadRef !== shareRef;
    probe(7, 1);
    waitRef(shareRef);
    probe(2, shareRef);
    baseSw <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      {raiseSw, lowerSw} <= i[1:0];
      expv = (i == 0) ? glm_pkg::BASEREF_RST : (i == 1) ? TRIP :
             (i == 2) ? glm_pkg::RATED_RST : remote;
      waitRef(expv);
      probe(2, expv);
    end
    // unload with raise and lower still held: they must not matter
    loadSw <= 1'b0;
    settle();
    tbFlag <= loadRef !== TRIP;
    probe(7, 1);
    waitRef(TRIP);
    probe(2, TRIP);
    tbFlag <= relay;
    probe(7, 0);
    sensorLoad <= TRIP;
    for (k = 0; k < 40 * TICK && relay !== 1'b1; k++)
      @(posedge sys_clk);
    for (k = 0; k < 10 * TICK && relay === 1'b1; k++)
      @(posedge sys_clk);
    tbFlag <= k >= 3 * TICK && k <= 4 * TICK + 2;
    probe(7, 1);
    settle();
    probe(1, 0);
    probe(4, 0);
    finish_test();
  end
endmodule : tb_top
